// >>> hdl/vsic_defines.svh
`ifndef VSIC_DEFINES_SVH
`define VSIC_DEFINES_SVH

// Register offsets
`define VSIC_REG_CLKGEN 8'h03
`define VSIC_REG_HSPOL 8'h12
`define VSIC_REG_VSPOL 8'h14
`define VSIC_REG_CLAMPCTL 8'h18
`define VSIC_REG_AUTOCTL 8'h19
`define VSIC_REG_POWER 8'h1e
`define VSIC_REG_SLICER 8'h20
`define VSIC_REG_CLDELAY 8'h21
`define VSIC_REG_CLDUR 8'h22
`define VSIC_REG_INSEL 8'h23
`define VSIC_REG_STATUS 8'h24

// Field positions
`define VSIC_EXTERNAL_PIXEL_CLOCK_IN_BIT 2
`define VSIC_POL_OVR_BIT 5
`define VSIC_POL_VAL_BIT 4
`define VSIC_CLAMP_POL_BIT 7
`define VSIC_COAST_POL_BIT 6
`define VSIC_EXTCLAMP_BIT 4
`define VSIC_AUTO_CLAMP_BIT 0
`define VSIC_AUTO_COAST_BIT 1
`define VSIC_INT_COAST_BIT 2
`define VSIC_PD_POL_BIT 2
`define VSIC_PD_MAN_BIT 3
`define VSIC_PD_SEL_BIT 4
`define VSIC_INSEL_B_BIT 0

// Slicer threshold in millivolts
`define VSIC_SLICE_STEP_MV 8
`define VSIC_SLICE_MIN_MV 8
`define VSIC_SLICE_MAX_MV 256
`define VSIC_SLICE_DEF_MV 128
`define VSIC_SLICE_DEF_CODE ((`VSIC_SLICE_DEF_MV - `VSIC_SLICE_MIN_MV) / `VSIC_SLICE_STEP_MV)

// Reset values
`define VSIC_RST_CLAMPCTL 8'h40
`define VSIC_RST_CLDELAY 8'h08
`define VSIC_RST_CLDUR 8'h14
`define VSIC_RST_ZERO 8'h00

`endif

// >>> hdl/vsic_input_ctrl.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "vsic_defines.svh"
// Summary of operation
// [RL1] Hsync polarity auto-detected or manually set
// [RL2] Hsync leading edge to PLL, trailing to clamp
// [RL3] Polarity 0 falling edge, 1 rising edge
// [RL4] Vsync polarity selectable; drives field and coast
// [RL5] Slicer threshold 8-256 mV, default 128 mV
// [RL6] Sliced sync output is noninverting
// [RL7] External clamp only when enable bit set
// [RL8] Otherwise internal clamp: delay then duration
// [RL9] Clamp polarity auto-detected or manually set
// [RL10] Coast freezes PLL synchronisation to hsync
// [RL11] Coast polarity resets to 1, selectable
// [RL12] External pixel clock selected by control bit
// [RL13] Shared pin functions independent of each other
// [RL14] Power-down pin combined with manual control bits
// [RL15] Unused pin: active-high polarity, pin tied low
// [RL16] Source asserts clamp during back porch only
// [RL17] Async inputs synchronised before polarity and edges
module vsic_input_ctrl #(
	parameter int LINE_W = 16,
	parameter int DET_W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire vsic_pkg::vsic_byte_type reg_addr_i,
	input wire vsic_pkg::vsic_byte_type reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output vsic_pkg::vsic_byte_type reg_rdata_o,
	input wire logic horiz_sync_in_a_i,
	input wire logic horiz_sync_in_b_i,
	input wire logic vert_sync_in_a_i,
	input wire logic vert_sync_in_b_i,
	input wire logic green_embedded_sync_in_a_i,
	input wire logic green_embedded_sync_in_b_i,
	input wire logic clamp_pin_i,
	input wire logic external_pixel_clock_in_i,
	input wire logic sleep_control_pin_i,
	output logic pll_ref_edge_o,
	output logic pll_coast_o,
	output logic ext_clk_sel_o,
	output logic clamp_o,
	output logic sliced_sync_output_o,
	output logic [4:0] slicer_code_o,
	output logic vsync_active_o,
	output logic field_odd_o,
	output logic power_down_o
);
	import vsic_pkg::*;

	localparam int IDX_HS = 0;
	localparam int IDX_VS = 1;
	localparam int IDX_SOG = 2;
	localparam int IDX_CLP = 3;
	localparam int IDX_CST = 4;
	localparam int IDX_PD = 5;
	localparam int NPIN = 6;
	localparam int NCHB = 3;
	localparam int NDET = NPIN + NCHB;

	typedef struct packed {
		vsic_byte_type reg_clk;
		vsic_byte_type reg_hs;
		vsic_byte_type reg_vs;
		vsic_byte_type reg_clctl;
		vsic_byte_type reg_auto;
		vsic_byte_type reg_pwr;
		vsic_byte_type reg_slice;
		vsic_byte_type reg_cldly;
		vsic_byte_type reg_cldur;
		vsic_byte_type reg_insel;
		vsic_byte_type rdata;
		vsic_clamp_state_type cl_state;
		logic [7:0] cl_cnt;
		logic [LINE_W-1:0] line_cnt;
		logic [LINE_W-1:0] line_len;
		logic field_odd;
		logic pll_ref;
		logic coast;
		logic extsel;
		logic clamp;
		logic sliced;
		logic vsact;
		logic pd;
	} vsic_top_state_type;

	vsic_top_state_type st;
	vsic_top_state_type next_st;

	logic [NDET-1:0] pin_mux;
	logic [NDET-1:0] man_en;
	logic [NDET-1:0] man_pol;
	logic [NDET-1:0] lvl_raw, act_raw, lead_raw, trail_raw, det_raw;
	logic chb;
	logic [NPIN-1:0] lvl;
	logic [NPIN-1:0] act;
	logic [NPIN-1:0] lead;
	logic [NPIN-1:0] trail;
	logic [NPIN-1:0] det;

	function automatic vsic_byte_type reg_read(input vsic_byte_type addr,
		input vsic_top_state_type s, input logic [NPIN-1:0] d);
		case (addr)
			`VSIC_REG_CLKGEN: reg_read = s.reg_clk;
			`VSIC_REG_HSPOL: reg_read = s.reg_hs;
			`VSIC_REG_VSPOL: reg_read = s.reg_vs;
			`VSIC_REG_CLAMPCTL: reg_read = s.reg_clctl;
			`VSIC_REG_AUTOCTL: reg_read = s.reg_auto;
			`VSIC_REG_POWER: reg_read = s.reg_pwr;
			`VSIC_REG_SLICER: reg_read = s.reg_slice;
			`VSIC_REG_CLDELAY: reg_read = s.reg_cldly;
			`VSIC_REG_CLDUR: reg_read = s.reg_cldur;
			`VSIC_REG_INSEL: reg_read = s.reg_insel;
			`VSIC_REG_STATUS: reg_read = {s.pd, s.field_odd, s.coast, s.clamp,
				d[IDX_CST], d[IDX_CLP], d[IDX_VS], d[IDX_HS]};
			default: reg_read = 8'h00;
		endcase
	endfunction

	// Pins synchronised first, channel picked after
	always_comb begin
		pin_mux[IDX_HS] = horiz_sync_in_a_i;
		pin_mux[IDX_VS] = vert_sync_in_a_i;
		pin_mux[IDX_SOG] = green_embedded_sync_in_a_i;
		pin_mux[NPIN + IDX_HS] = horiz_sync_in_b_i;
		pin_mux[NPIN + IDX_VS] = vert_sync_in_b_i;
		pin_mux[NPIN + IDX_SOG] = green_embedded_sync_in_b_i;
		pin_mux[IDX_CLP] = clamp_pin_i;
		pin_mux[IDX_CST] = external_pixel_clock_in_i; // RL13
		pin_mux[IDX_PD] = sleep_control_pin_i;
		man_en[IDX_HS] = st.reg_hs[`VSIC_POL_OVR_BIT]; // RL1
		man_pol[IDX_HS] = st.reg_hs[`VSIC_POL_VAL_BIT]; // RL3
		man_en[IDX_VS] = st.reg_vs[`VSIC_POL_OVR_BIT]; // RL4
		man_pol[IDX_VS] = st.reg_vs[`VSIC_POL_VAL_BIT];
		man_en[IDX_SOG] = 1'b1; // RL6
		man_pol[IDX_SOG] = 1'b1;
		man_en[IDX_CLP] = ~st.reg_auto[`VSIC_AUTO_CLAMP_BIT]; // RL9
		man_pol[IDX_CLP] = st.reg_clctl[`VSIC_CLAMP_POL_BIT];
		man_en[IDX_CST] = ~st.reg_auto[`VSIC_AUTO_COAST_BIT]; // RL11
		man_pol[IDX_CST] = st.reg_clctl[`VSIC_COAST_POL_BIT];
		man_en[IDX_PD] = 1'b1;
		man_pol[IDX_PD] = st.reg_pwr[`VSIC_PD_POL_BIT];
		man_en[NDET-1:NPIN] = man_en[NCHB-1:0];
		man_pol[NDET-1:NPIN] = man_pol[NCHB-1:0];
	end

	generate
		for (genvar g = 0; g < NDET; g++) begin : g_pin
			vsic_sync_det #(
				.CNT_W(DET_W)
			) u_det (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(pin_mux[g]),
				.man_en_i(man_en[g]),
				.man_pol_i(man_pol[g]),
				.lvl_o(lvl_raw[g]),
				.act_o(act_raw[g]),
				.lead_o(lead_raw[g]),
				.trail_o(trail_raw[g]),
				.det_pol_o(det_raw[g])
			);
		end
	endgenerate

	// Channel b detectors take the low three slots
	function automatic logic [NPIN-1:0] chan_pick(input logic [NDET-1:0] r, input logic b);
		chan_pick = b ? {r[NPIN-1:NCHB], r[NDET-1:NPIN]} : r[NPIN-1:0];
	endfunction
	assign chb = st.reg_insel[`VSIC_INSEL_B_BIT];
	assign lvl = chan_pick(lvl_raw, chb);
	assign act = chan_pick(act_raw, chb);
	assign lead = chan_pick(lead_raw, chb);
	assign trail = chan_pick(trail_raw, chb);
	assign det = chan_pick(det_raw, chb);

	always_comb begin
		next_st = st;
		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				`VSIC_REG_CLKGEN: next_st.reg_clk = reg_wdata_i;
				`VSIC_REG_HSPOL: next_st.reg_hs = reg_wdata_i;
				`VSIC_REG_VSPOL: next_st.reg_vs = reg_wdata_i;
				`VSIC_REG_CLAMPCTL: next_st.reg_clctl = reg_wdata_i;
				`VSIC_REG_AUTOCTL: next_st.reg_auto = reg_wdata_i;
				`VSIC_REG_POWER: next_st.reg_pwr = reg_wdata_i;
				`VSIC_REG_SLICER: next_st.reg_slice = {3'h0, reg_wdata_i[4:0]}; // RL5
				`VSIC_REG_CLDELAY: next_st.reg_cldly = reg_wdata_i;
				`VSIC_REG_CLDUR: next_st.reg_cldur = reg_wdata_i;
				`VSIC_REG_INSEL: next_st.reg_insel = reg_wdata_i;
				default: next_st.reg_clk = st.reg_clk;
			endcase
		end
		next_st.rdata = reg_rd_i ? reg_read(reg_addr_i, st, det) : 8'h00;

		// Internal clamp timer, restarted by every trailing edge
		case (st.cl_state)
			CL_IDLE: begin
				next_st.cl_cnt = st.cl_cnt;
			end
			CL_DELAY: begin
				if (st.cl_cnt == 8'h00) begin
					next_st.cl_state = CL_ACTIVE;
					next_st.cl_cnt = st.reg_cldur;
				end else begin
					next_st.cl_cnt = st.cl_cnt - 8'h01;
				end
			end
			CL_ACTIVE: begin
				if (st.cl_cnt == 8'h00) begin
					next_st.cl_state = CL_IDLE;
				end else begin
					next_st.cl_cnt = st.cl_cnt - 8'h01;
				end
			end
			default: begin
				next_st.cl_state = CL_IDLE;
			end
		endcase
		if (trail[IDX_HS]) begin // RL2
			next_st.cl_state = CL_DELAY; // RL8
			next_st.cl_cnt = st.reg_cldly;
		end

		// Line length and field detection
		if (lead[IDX_HS]) begin
			next_st.line_len = st.line_cnt;
			next_st.line_cnt = '0;
		end else if (!(&st.line_cnt)) begin
			next_st.line_cnt = st.line_cnt + 1'b1;
		end
		if (lead[IDX_VS]) begin // RL4
			next_st.field_odd = st.line_cnt >= (st.line_len >> 1);
		end

		// Outputs follow the updated registers
		next_st.coast = act[IDX_CST] | (next_st.reg_auto[`VSIC_INT_COAST_BIT] & act[IDX_VS]); // RL4
		next_st.pll_ref = lead[IDX_HS] & ~next_st.coast; // RL10
		next_st.extsel = next_st.reg_clk[`VSIC_EXTERNAL_PIXEL_CLOCK_IN_BIT]; // RL12
		next_st.clamp = next_st.reg_clctl[`VSIC_EXTCLAMP_BIT] ? act[IDX_CLP] // RL7
			: (next_st.cl_state == CL_ACTIVE); // RL8
		next_st.sliced = lvl[IDX_SOG]; // RL6
		next_st.vsact = act[IDX_VS];
		next_st.pd = next_st.reg_pwr[`VSIC_PD_SEL_BIT] // RL14
			& (next_st.reg_pwr[`VSIC_PD_MAN_BIT] | act[IDX_PD]);

		if (sys_rst_i) begin
			next_st = '0;
			next_st.cl_state = CL_IDLE;
			next_st.reg_clctl = `VSIC_RST_CLAMPCTL; // RL11
			next_st.reg_slice = 8'(`VSIC_SLICE_DEF_CODE); // RL5
			next_st.reg_cldly = `VSIC_RST_CLDELAY;
			next_st.reg_cldur = `VSIC_RST_CLDUR;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign reg_rdata_o = st.rdata;
	assign pll_ref_edge_o = st.pll_ref;
	assign pll_coast_o = st.coast;
	assign ext_clk_sel_o = st.extsel;
	assign clamp_o = st.clamp;
	assign sliced_sync_output_o = st.sliced;
	assign slicer_code_o = st.reg_slice[4:0];
	assign vsync_active_o = st.vsact;
	assign field_odd_o = st.field_odd;
	assign power_down_o = st.pd;

	property p_hs_manual_pol;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st.reg_hs[`VSIC_POL_OVR_BIT] && lead[IDX_HS])
			|-> lvl[IDX_HS] == st.reg_hs[`VSIC_POL_VAL_BIT]
			&& lvl[IDX_HS] != (chb ? $past(lvl_raw[NPIN + IDX_HS]) : $past(lvl_raw[IDX_HS]));
	endproperty
	a_hs_manual_pol: assert property (p_hs_manual_pol) else $error("hsync edge sense wrong"); // RL3

	property p_pll_ref_lead;
		@(posedge clk_i) disable iff (sys_rst_i)
		pll_ref_edge_o |-> $past(lead[IDX_HS]) && !pll_coast_o;
	endproperty
	a_pll_ref_lead: assert property (p_pll_ref_lead) else $error("pll reference not leading edge"); // RL2

	property p_coast_blocks_ref;
		@(posedge clk_i) disable iff (sys_rst_i)
		(lead[IDX_HS] && act[IDX_CST]) |=> !pll_ref_edge_o && pll_coast_o;
	endproperty
	a_coast_blocks_ref: assert property (p_coast_blocks_ref) else $error("pll synced while coasting"); // RL10

	property p_vs_manual_pol;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st.reg_vs[`VSIC_POL_OVR_BIT] && lead[IDX_VS]) |-> lvl[IDX_VS] == st.reg_vs[`VSIC_POL_VAL_BIT];
	endproperty
	a_vs_manual_pol: assert property (p_vs_manual_pol) else $error("vsync edge sense wrong"); // RL4

	property p_reset_values;
		@(posedge clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> !st.reg_clctl[`VSIC_EXTCLAMP_BIT] && st.reg_clctl[`VSIC_COAST_POL_BIT]
			&& slicer_code_o == 5'h0f;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("control reset value wrong"); // RL11

	property p_ext_clamp_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st.reg_clctl[`VSIC_EXTCLAMP_BIT] && !reg_wr_i) |=> clamp_o == $past(act[IDX_CLP]);
	endproperty
	a_ext_clamp_follow: assert property (p_ext_clamp_follow) else $error("clamp pin not followed"); // RL7

	property p_int_clamp_delay;
		@(posedge clk_i) disable iff (sys_rst_i)
		(trail[IDX_HS] && !st.reg_clctl[`VSIC_EXTCLAMP_BIT] && !reg_wr_i) |=> !clamp_o;
	endproperty
	a_int_clamp_delay: assert property (p_int_clamp_delay) else $error("clamp not delayed"); // RL8

	property p_external_pixel_clock_in_sel;
		@(posedge clk_i) disable iff (sys_rst_i)
		(reg_wr_i && reg_addr_i == `VSIC_REG_CLKGEN) |=> ext_clk_sel_o == $past(reg_wdata_i[2]);
	endproperty
	a_external_pixel_clock_in_sel: assert property (p_external_pixel_clock_in_sel) else $error("external clock select wrong"); // RL12

	property p_sliced_follow;
		@(posedge clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> sliced_sync_output_o == $past(lvl[IDX_SOG]);
	endproperty
	a_sliced_follow: assert property (p_sliced_follow) else $error("sliced sync inverted"); // RL6

	property p_manual_pd;
		@(posedge clk_i) disable iff (sys_rst_i)
		(st.reg_pwr[`VSIC_PD_SEL_BIT] && st.reg_pwr[`VSIC_PD_MAN_BIT] && !reg_wr_i) |=> power_down_o;
	endproperty
	a_manual_pd: assert property (p_manual_pd) else $error("manual power-down ignored"); // RL14

endmodule

// >>> hdl/vsic_pkg.sv
package vsic_pkg;

	typedef logic [7:0] vsic_byte_type;

	typedef enum logic [1:0] {
		CL_IDLE,
		CL_DELAY,
		CL_ACTIVE
	} vsic_clamp_state_type;

endpackage

// >>> hdl/vsic_sync_det.sv
`timescale 1ns/1ps

module vsic_sync_det #(
	parameter int CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	input wire logic man_en_i,
	input wire logic man_pol_i,
	output logic lvl_o,
	output logic act_o,
	output logic lead_o,
	output logic trail_o,
	output logic det_pol_o
);
	import vsic_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] hi_len;
		logic det_pol;
	} vsic_det_state_type;

	vsic_det_state_type st;
	vsic_det_state_type next_st;
	logic rise;
	logic fall;
	logic pol;

	always_comb begin
		rise = st.s2 & ~st.s3;
		fall = ~st.s2 & st.s3;
		pol = man_en_i ? man_pol_i : st.det_pol;
		next_st = st;
		// Two-stage synchroniser, third stage only for edges
		next_st.s1 = pin_i; // RL17
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (rise || fall) begin
			next_st.cnt = '0;
		end else if (!(&st.cnt)) begin
			next_st.cnt = st.cnt + 1'b1;
		end
		if (fall) begin
			next_st.hi_len = st.cnt;
		end
		// Shorter phase is the sync pulse
		if (rise) begin
			next_st.det_pol = st.hi_len < st.cnt;
		end
		if (sys_rst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign lvl_o = st.s2;
	assign act_o = pol ? st.s2 : ~st.s2;
	assign lead_o = pol ? rise : fall;
	assign trail_o = pol ? fall : rise;
	assign det_pol_o = st.det_pol;

	property p_edge_after_sync;
		@(posedge clk_i) disable iff (sys_rst_i)
		(lead_o || trail_o) |-> (st.s3 == $past(st.s2)) && (st.s3 != st.s2);
	endproperty
	a_edge_after_sync: assert property (p_edge_after_sync) else $error("edge not from synced level"); // RL17

endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
	import vsic_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	vsic_byte_type addr = 8'h00;
	vsic_byte_type wdata = 8'h00;
	vsic_byte_type rdata;
	logic hs_pol = 1'b0;
	logic [3:0] width = 4'h6;
	logic chan_b = 1'b0;
	logic coast_pin = 1'b0;
	logic sleep_pin = 1'b0;
	logic [2:0] noise = 3'h0;
	logic m_hs, m_vs, m_sog, m_cl;
	logic [5:0] cnt;
	logic ref_edge, coast, ext_sel, clamp, sliced, vs_act, field, pd;
	logic [4:0] code;
	logic sl, sh, va, co, mv;
	int seed = 32'hc09f;
	int miscompares = 0;
	int compares = 0;
	int ep, ne, cf, cc, dly, dur, k;
	vsic_byte_type pdr[5] = '{8'h18, 8'h14, 8'h14, 8'h08, 8'h10};
	logic [4:0] pdp = 5'b01100;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) noise <= 3'($random(seed));

	vsic_src_model u_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hs_pol_i(hs_pol),
		.width_i(width), .hsync_o(m_hs), .vsync_o(m_vs), .sog_o(m_sog), .clamp_o(m_cl),
		.cnt_o(cnt));

	vsic_input_ctrl u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.horiz_sync_in_a_i(chan_b ? noise[0] : m_hs), .horiz_sync_in_b_i(chan_b ? m_hs : noise[0]),
		.vert_sync_in_a_i(chan_b ? noise[1] : m_vs), .vert_sync_in_b_i(chan_b ? m_vs : noise[1]),
		.green_embedded_sync_in_a_i(chan_b ? noise[2] : m_sog),
		.green_embedded_sync_in_b_i(chan_b ? m_sog : noise[2]),
		.clamp_pin_i(m_cl), .external_pixel_clock_in_i(coast_pin),
		.sleep_control_pin_i(sleep_pin), .pll_ref_edge_o(ref_edge), .pll_coast_o(coast),
		.ext_clk_sel_o(ext_sel), .clamp_o(clamp), .sliced_sync_output_o(sliced),
		.slicer_code_o(code), .vsync_active_o(vs_act), .field_odd_o(field),
		.power_down_o(pd));

	function automatic int exp_clamp(input int trail, input int d);
		return trail + d + 4;
	endfunction
	function automatic int code_of(input int mv_in);
		return (mv_in - 8) / 8;
	endfunction
	function automatic logic exp_pd(input vsic_byte_type r, input logic pin);
		return r[4] & (r[3] | (pin == r[2]));
	endfunction

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic wr(input vsic_byte_type a, input vsic_byte_type d);
		@(posedge clk_i);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input vsic_byte_type a, input vsic_byte_type e, input string msg);
		@(posedge clk_i);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		chk(rdata, e, msg);
	endtask
	// Gathers one full line of output activity
	task automatic line_stats();
		int i;
		ep = -1;
		ne = 0;
		cf = -1;
		cc = 0;
		for (i = 0; i < 70; i++) begin
			@(posedge clk_i);
			#1;
			if (cnt === 6'h00) break;
		end
		if (i == 70) begin
			miscompares++;
			conclude();
		end
		for (i = 0; i < 64; i++) begin
			if (ref_edge === 1'b1) begin
				ne++;
				if (ep < 0) ep = cnt;
			end
			if (clamp === 1'b1) begin
				cc++;
				if (cf < 0) cf = cnt;
			end
			if (cnt == 6'(width)) sl = sliced;
			if (cnt == 6'h28) begin
				sh = sliced;
				va = vs_act;
				co = coast;
				mv = m_vs;
			end
			@(posedge clk_i);
			#1;
		end
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h18, 8'h40, "clamp ctl reset");
		rd(8'h21, 8'h08, "delay reset");
		rd(8'h22, 8'h14, "duration reset");
		rd(8'h7f, 8'h00, "unmapped read");
		chk(code, code_of(128), "slicer reset");
		done("reset");
		for (k = 0; k < 5; k++) begin
			dly = 1 + ($random(seed) & 7);
			dur = $random(seed) & 15;
			wr(8'h21, 8'(dly));
			wr(8'h22, 8'(dur));
			wr(8'h12, (k < 2) ? 8'h00 : (k == 3) ? 8'h30 : 8'h20);
			@(posedge clk_i);
			hs_pol <= k[0] | (k == 4);
			width <= 4'(4 + ($random(seed) & 7));
			repeat (4) line_stats();
			chk(ep, (k == 4) ? width + 3 : 3, "pll edge position");
			chk(ne, 1, "pll edges per line");
			chk(cf, exp_clamp((k == 4) ? 0 : width, dly), "clamp start");
			chk(cc, dur + 1, "clamp length");
			chk(sl, 1'b0, "sliced in sync");
			chk(sh, 1'b1, "sliced idle");
		end
		done("polarity and internal clamp");
		wr(8'h12, 8'h30);
		wr(8'h18, 8'hd0);
		repeat (2) line_stats();
		chk(cc, 4, "ext clamp high");
		wr(8'h18, 8'h50);
		repeat (2) line_stats();
		chk(cc, 60, "ext clamp low");
		wr(8'h19, 8'h01);
		repeat (2) line_stats();
		chk(cc, 4, "ext clamp auto polarity");
		wr(8'h19, 8'h00);
		wr(8'h18, 8'h40);
		done("external clamp");
		@(posedge clk_i);
		coast_pin <= 1'b1;
		repeat (2) line_stats();
		chk(ne, 0, "edges while coasting");
		chk(co, 1'b1, "coast default polarity");
		wr(8'h03, 8'h04);
		line_stats();
		chk(ext_sel, 1'b1, "ext clock select");
		chk(ne, 0, "coast with ext clock");
		@(posedge clk_i);
		coast_pin <= 1'b0;
		repeat (2) line_stats();
		chk(ne, 1, "edges after coast");
		wr(8'h18, 8'h00);
		repeat (2) line_stats();
		chk(co, 1'b1, "coast active low");
		wr(8'h18, 8'h40);
		wr(8'h03, 8'h00);
		done("coast");
		wr(8'h14, 8'h20);
		wr(8'h19, 8'h04);
		repeat (8) begin
			line_stats();
			chk(va, !mv, "vsync level");
			chk(co, !mv, "coast from vsync");
			repeat (64) @(posedge clk_i);
		end
		chk(field, 1'b1, "field flag");
		wr(8'h19, 8'h00);
		done("vsync");
		@(posedge clk_i);
		chan_b <= 1'b1;
		wr(8'h23, 8'h01);
		repeat (3) line_stats();
		chk(ep, 3, "channel b edge");
		done("channel b");
		for (k = 0; k < 4; k++) begin
			dly = (k == 0) ? 0 : (k == 1) ? 31 : ($random(seed) & 31);
			wr(8'h20, 8'(dly) | 8'he0);
			rd(8'h20, 8'(dly), "slicer readback");
			chk(code, dly, "slicer code");
		end
		done("slicer");
		for (k = 0; k < 5; k++) begin
			wr(8'h1e, pdr[k]);
			@(posedge clk_i);
			sleep_pin <= pdp[k];
			repeat (8) @(posedge clk_i);
			#1;
			chk(pd, exp_pd(pdr[k], pdp[k]), "power down");
		end
		done("power down");
		conclude();
	end
endmodule

// >>> verification/vsic_src_model.sv
`timescale 1ns/1ps
module vsic_src_model (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic hs_pol_i,
	input wire logic [3:0] width_i,
	output logic hsync_o,
	output logic vsync_o,
	output logic sog_o,
	output logic clamp_o,
	output logic [5:0] cnt_o
);
	logic [1:0] line;
	logic in_sync;
	// 64-cycle lines, four lines a frame
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_o <= 6'h00;
			line <= 2'h0;
		end else begin
			cnt_o <= cnt_o + 6'h01;
			if (cnt_o == 6'h3f) begin
				line <= line + 2'h1;
			end
		end
	end
	assign in_sync = cnt_o < 6'(width_i);
	assign hsync_o = in_sync ~^ hs_pol_i;
	assign sog_o = !in_sync;
	assign vsync_o = line != 2'h0;
	// Clamp only in back porch, active high
	assign clamp_o = (cnt_o >= 6'(width_i) + 6'h02) && (cnt_o < 6'(width_i) + 6'h06);
endmodule
